// ==== design/psda_addr.sv ====
// package and program address former for the program space data access block
`timescale 1ns/1ps
package psda_pkg;
  localparam int PM_W = 24;
  localparam int DW = 16;
  localparam int PAGE_W = 8;
  localparam int PC_W = 23;
  localparam int LANES = 3;
  localparam int BYTE_W = 8;
  localparam int CFG_BIT = 7;
  localparam int WIN_EA_W = 15;
  localparam logic [LANES-1:0] LANE_ALL = 3'h7;
  localparam logic [LANES-1:0] LANE_LOW_WORD = 3'h3;
  localparam logic [LANES-1:0] LANE_B0 = 3'h1;
  localparam logic [LANES-1:0] LANE_B1 = 3'h2;
  localparam logic [LANES-1:0] LANE_HI = 3'h4;
  localparam logic [LANES-1:0] LANE_NONE = 3'h0;
  localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  typedef enum logic [1:0] {PSDA_FETCH, PSDA_TABLE, PSDA_WINDOW} psda_kind_t;
  typedef enum logic {PSDA_IDLE, PSDA_WAIT} psda_state_t;
endpackage

module psda_addr_gen
  import psda_pkg::*;
(
  input wire psda_kind_t kind,
  input wire logic [PC_W-1:0] pc,
  input wire logic [PAGE_W-1:0] table_page_select,
  input wire logic [PAGE_W-1:0] window_page,
  input wire logic [DW-1:0] ea,
  input wire logic tbl_high,
  input wire logic tbl_byte,
  input wire logic [DW-1:0] wdata,
  output logic [PM_W-1:0] addr,
  output logic [LANES-1:0] lane_en,
  output logic [PM_W-1:0] wdata_pm
);
  logic [BYTE_W-1:0] wbyte [LANES];

  // per lane write byte: upper lane takes low byte, byte writes replicate
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    assign wbyte[i] = (i == LANES - 1 || tbl_byte) ? wdata[BYTE_W-1:0]
                                                  : wdata[(i % 2) * BYTE_W +: BYTE_W];
  end
  assign wdata_pm = {wbyte[2], wbyte[1], wbyte[0]};

  // address and lane enables per access kind
  always_comb
  begin
    addr = '0;
    lane_en = LANE_NONE;
    unique case (kind)
      PSDA_FETCH:
      begin
        addr = {1'b0, pc[PC_W-1:1], 1'b0};
        lane_en = LANE_ALL;
      end
      PSDA_TABLE:
      begin
        addr = {table_page_select, ea};
        if (tbl_high)
          lane_en = ea[0] ? LANE_NONE : LANE_HI;
        else if (tbl_byte)
          lane_en = ea[0] ? LANE_B1 : LANE_B0;
        else
          lane_en = LANE_LOW_WORD;
      end
      PSDA_WINDOW:
      begin
        addr = {1'b0, window_page, ea[WIN_EA_W-1:0]};
        lane_en = LANE_LOW_WORD;
      end
      default:
      begin
        addr = '0;
        lane_en = LANE_NONE;
      end
    endcase
  end
endmodule // psda_addr_gen

// ==== design/psda_top.sv ====
// program space data access: fetch, table and read-only window sequencing
`timescale 1ns/1ps
module psda_top
  import psda_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic fetch_req,
  input wire logic [PC_W-1:0] fetch_pc,
  input wire logic tbl_req,
  input wire logic tbl_wr,
  input wire logic tbl_high,
  input wire logic tbl_byte,
  input wire logic [DW-1:0] tbl_ea,
  input wire logic [DW-1:0] tbl_wdata,
  input wire logic win_req,
  input wire logic win_wr,
  input wire logic [DW-1:0] win_ea,
  input wire logic page_wr,
  input wire logic [PAGE_W-1:0] page_wdata,
  input wire logic win_page_wr,
  input wire logic [PAGE_W-1:0] win_page_wdata,
  input wire logic [PM_W-1:0] pm_rdata,
  input wire logic pm_rvalid,
  output logic req_ready,
  output logic [PAGE_W-1:0] table_page_select,
  output logic [PM_W-1:0] pm_addr,
  output logic pm_rd,
  output logic pm_wr,
  output logic [LANES-1:0] pm_lane_en,
  output logic [PM_W-1:0] pm_wdata,
  output logic cfg_space,
  output logic resp_valid,
  output logic [DW-1:0] resp_data,
  output logic fetch_valid,
  output logic [PM_W-1:0] fetch_instr,
  output logic win_wr_drop
);
  psda_state_t st_q;
  psda_kind_t kind_sel;
  psda_kind_t rkind_q;
  logic [PAGE_W-1:0] page_q;
  logic [PAGE_W-1:0] win_page_q;
  logic [DW-1:0] ea_sel;
  logic take;
  logic is_wr;
  logic r_high_q;
  logic r_byte_q;
  logic r_ea0_q;
  logic [PM_W-1:0] addr_d;
  logic [LANES-1:0] lane_d;
  logic [PM_W-1:0] wdata_d;

  // arbitration: table first, then window, then fetch
  always_comb
  begin
    kind_sel = PSDA_FETCH;
    ea_sel = tbl_ea;
    if (tbl_req)
      kind_sel = PSDA_TABLE;
    else if (win_req)
    begin
      kind_sel = PSDA_WINDOW;
      ea_sel = win_ea;
    end
  end
  assign take = req_ready && (tbl_req || win_req || fetch_req);
  assign is_wr = tbl_req ? tbl_wr : (win_req && win_wr);

  psda_addr_gen u_addr_gen (
    .kind(kind_sel),
    .pc(fetch_pc),
    .table_page_select(page_q),
    .window_page(win_page_q),
    .ea(ea_sel),
    .tbl_high(tbl_high),
    .tbl_byte(tbl_byte),
    .wdata(tbl_wdata),
    .addr(addr_d),
    .lane_en(lane_d),
    .wdata_pm(wdata_d)
  );

  // page registers written by the core
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      page_q <= PAGE_RST;
      win_page_q <= PAGE_RST;
    end
    else
    begin
      if (page_wr)
        page_q <= page_wdata;
      if (win_page_wr)
        win_page_q <= win_page_wdata;
    end
  end
  assign table_page_select = page_q;

  // sequencer: one read outstanding at a time
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= PSDA_IDLE;
      req_ready <= 1'b1;
    end
    else
    begin
      unique case (st_q)
        PSDA_IDLE:
          if (take && !is_wr)
          begin
            st_q <= PSDA_WAIT;
            req_ready <= 1'b0;
          end
        PSDA_WAIT:
          if (pm_rvalid)
          begin
            st_q <= PSDA_IDLE;
            req_ready <= 1'b1;
          end
      endcase
    end
  end

  // program memory command issue
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pm_addr <= '0;
      pm_rd <= 1'b0;
      pm_wr <= 1'b0;
      pm_lane_en <= LANE_NONE;
      pm_wdata <= '0;
      cfg_space <= 1'b0;
      win_wr_drop <= 1'b0;
    end
    else
    begin
      pm_rd <= take && !is_wr;
      pm_wr <= take && is_wr && kind_sel == PSDA_TABLE;
      win_wr_drop <= take && is_wr && kind_sel == PSDA_WINDOW;
      if (take)
      begin
        pm_addr <= addr_d;
        pm_lane_en <= lane_d;
        pm_wdata <= wdata_d;
        cfg_space <= kind_sel == PSDA_TABLE && page_q[CFG_BIT];
      end
    end
  end

  // remember what the outstanding read needs for its answer
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rkind_q <= PSDA_FETCH;
      r_high_q <= 1'b0;
      r_byte_q <= 1'b0;
      r_ea0_q <= 1'b0;
    end
    else if (take && !is_wr)
    begin
      rkind_q <= kind_sel;
      r_high_q <= tbl_high;
      r_byte_q <= tbl_byte;
      r_ea0_q <= ea_sel[0];
    end
  end

  // read answers: fetch gets the full word, data side gets 16 bits
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      resp_valid <= 1'b0;
      resp_data <= '0;
      fetch_valid <= 1'b0;
      fetch_instr <= '0;
    end
    else
    begin
      resp_valid <= st_q == PSDA_WAIT && pm_rvalid && rkind_q != PSDA_FETCH;
      fetch_valid <= st_q == PSDA_WAIT && pm_rvalid && rkind_q == PSDA_FETCH;
      if (st_q == PSDA_WAIT && pm_rvalid)
      begin
        fetch_instr <= pm_rdata;
        if (rkind_q == PSDA_TABLE && r_high_q)
          resp_data <= {BYTE_ZERO, r_ea0_q ? BYTE_ZERO : pm_rdata[PM_W-1 -: BYTE_W]};
        else if (rkind_q == PSDA_TABLE && r_byte_q)
          resp_data <= {BYTE_ZERO, pm_rdata[r_ea0_q * BYTE_W +: BYTE_W]};
        else
          resp_data <= pm_rdata[DW-1:0];
      end
    end
  end

  // checks
  sequence s_tbl_take;
    req_ready && tbl_req;
  endsequence
  sequence s_win_take;
    req_ready && !tbl_req && win_req;
  endsequence

  a_fetch_addr_form: assert property (@(posedge clk_sys) disable iff (!rstn)
    req_ready && fetch_req && !tbl_req && !win_req |=>
      pm_rd && pm_addr == {1'b0, $past(fetch_pc[PC_W-1:1]), 1'b0})
    else $error("fetch address malformed");
  a_tbl_addr_form: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_tbl_take |=> pm_addr == {$past(page_q), $past(tbl_ea)}
      && cfg_space == $past(page_q[CFG_BIT]))
    else $error("table address malformed");
  a_tbl_issues_op: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_tbl_take |=> (pm_wr == $past(tbl_wr)) && (pm_rd != $past(tbl_wr)))
    else $error("table op not issued");
  a_win_no_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_win_take and win_wr |=> !pm_wr && !pm_rd && win_wr_drop ##1 req_ready)
    else $error("window write reached memory");
  a_win_low_word: assert property (@(posedge clk_sys) disable iff (!rstn)
    st_q == PSDA_WAIT && pm_rvalid && rkind_q == PSDA_WINDOW |=>
      resp_valid && resp_data == $past(pm_rdata[DW-1:0]))
    else $error("window read not low word");
  a_tbl_high_byte: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_tbl_take and tbl_high && !tbl_ea[0] && tbl_wr |=> pm_wr && pm_lane_en == LANE_HI)
    else $error("upper byte not written");
  a_tbl_byte_sel: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_tbl_take and tbl_byte && !tbl_high |=>
      pm_lane_en == ($past(tbl_ea[0]) ? LANE_B1 : LANE_B0))
    else $error("byte lane select wrong");
  a_fetch_full_word: assert property (@(posedge clk_sys) disable iff (!rstn)
    st_q == PSDA_WAIT && pm_rvalid && rkind_q == PSDA_FETCH |=>
      fetch_valid && !resp_valid && fetch_instr == $past(pm_rdata))
    else $error("fetch word not returned whole");
  a_win_addr_align: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_win_take and !win_wr |=> pm_lane_en == LANE_LOW_WORD
      && pm_addr == {1'b0, $past(win_page_q), $past(win_ea[WIN_EA_W-1:0])})
    else $error("window address misaligned");
endmodule // psda_top

// ==== test/psda_pm_model.sv ====
// program memory model answering read and write commands of the block
`timescale 1ns/1ps
module psda_pm_model
  import psda_pkg::*;
(
  input wire logic clk_sys,
  input wire logic pm_rd,
  input wire logic pm_wr,
  input wire logic [PM_W-1:0] pm_addr,
  input wire logic [LANES-1:0] pm_lane_en,
  input wire logic [PM_W-1:0] pm_wdata,
  input wire logic [3:0] delay,
  output logic [PM_W-1:0] pm_rdata,
  output logic pm_rvalid
);
  logic [PM_W-1:0] mem [16];
  logic [3:0] cnt = 4'h0;
  logic [3:0] idx = 4'h0;
  logic busy = 1'b0;
  // 24-bit words seeded with a distinct pattern per word; read port is driven by the clocked process only
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = {4'hA, i[3:0], 4'h5, i[3:0], 4'h3, i[3:0]};
  end
  // lane writes, delayed read answers; data toggles while not valid
  always @(posedge clk_sys)
  begin
    pm_rvalid <= 1'b0;
    pm_rdata <= ~pm_rdata;
    for (int l = 0; l < LANES; l++)
      if (pm_wr && pm_lane_en[l])
        mem[pm_addr[4:1]][l*8 +: 8] <= pm_wdata[l*8 +: 8];
    if (pm_rd)
    begin
      busy <= 1'b1;
      cnt <= delay;
      idx <= pm_addr[4:1];
    end
    else if (busy && cnt == 4'h0)
    begin
      busy <= 1'b0;
      pm_rvalid <= 1'b1;
      pm_rdata <= mem[idx];
    end
    else if (busy)
      cnt <= cnt - 4'h1;
  end
endmodule // psda_pm_model

// ==== test/testbench.sv ====
// self-checking bench for the program space data access block
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) report(48'(a), 48'(e)); end
module testbench
  import psda_pkg::*;
;
  logic clk_sys, rstn, fetch_req, tbl_req, tbl_wr, tbl_high, tbl_byte, win_req, win_wr;
  logic page_wr, win_page_wr, pm_rvalid, req_ready, pm_rd, pm_wr, cfg_space;
  logic resp_valid, fetch_valid, win_wr_drop;
  logic [PC_W-1:0] fetch_pc;
  logic [DW-1:0] tbl_ea, tbl_wdata, win_ea, resp_data;
  logic [PAGE_W-1:0] page_wdata, win_page_wdata, table_page_select;
  logic [PM_W-1:0] pm_rdata, pm_addr, pm_wdata, fetch_instr, r_addr, r_data;
  logic [LANES-1:0] pm_lane_en;
  logic [3:0] dly;
  int err_count = 0;
  int tests_run = 0;
  psda_top DUT (.clk_sys(clk_sys), .rstn(rstn), .fetch_req(fetch_req), .fetch_pc(fetch_pc),
    .tbl_req(tbl_req), .tbl_wr(tbl_wr), .tbl_high(tbl_high), .tbl_byte(tbl_byte),
    .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata), .win_req(win_req), .win_wr(win_wr),
    .win_ea(win_ea), .page_wr(page_wr), .page_wdata(page_wdata), .win_page_wr(win_page_wr),
    .win_page_wdata(win_page_wdata), .pm_rdata(pm_rdata), .pm_rvalid(pm_rvalid),
    .req_ready(req_ready), .table_page_select(table_page_select), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .pm_wr(pm_wr), .pm_lane_en(pm_lane_en), .pm_wdata(pm_wdata),
    .cfg_space(cfg_space), .resp_valid(resp_valid), .resp_data(resp_data),
    .fetch_valid(fetch_valid), .fetch_instr(fetch_instr), .win_wr_drop(win_wr_drop));
  psda_pm_model PM (.clk_sys(clk_sys), .pm_rd(pm_rd), .pm_wr(pm_wr), .pm_addr(pm_addr),
    .pm_lane_en(pm_lane_en), .pm_wdata(pm_wdata), .delay(dly), .pm_rdata(pm_rdata),
    .pm_rvalid(pm_rvalid));
  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;
  task automatic report(input logic [47:0] a, e);
    err_count++;
    $display("[ERR] %0t got %0h exp %0h", $time, a, e);
  endtask
  task automatic stop_test();
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic idle();
    {fetch_req, tbl_req, win_req} = 3'h0;
  endtask
  // one request; reads wait for the answer under a bound
  task automatic op(input int k, input logic w, h, b, input logic [15:0] ea, wd);
    int n;
    n = 0;
    `CHK(req_ready, 1'b1)
    {fetch_req, tbl_req, win_req} = {k == 0, k == 1, k == 2};
    {tbl_wr, win_wr, tbl_high, tbl_byte} = {w, w, h, b};
    {tbl_ea, win_ea, tbl_wdata, fetch_pc} = {ea, ea, wd, wd[6:0], ea};
    @(posedge clk_sys);
    #1 r_addr = pm_addr;
    if (!w)
    begin
      `CHK({pm_rd, req_ready}, 2'h2)
      idle();
      while (resp_valid !== 1'b1 && fetch_valid !== 1'b1)
      begin
        n++;
        if (n > 40)
        begin
          err_count++;
          stop_test();
        end
        @(posedge clk_sys);
        #1;
      end
      `CHK({fetch_valid, resp_valid}, {k == 0, k != 0})
      r_data = (k == 0) ? fetch_instr : {8'h00, resp_data};
    end
  endtask
  task automatic set_page(input logic [7:0] p, wp);
    {page_wr, win_page_wr, page_wdata, win_page_wdata} = {2'h3, p, wp};
    @(posedge clk_sys);
    #1 {page_wr, win_page_wr} = 2'h0;
    `CHK(table_page_select, p)
  endtask
  task automatic t_fetch();
    op(0, 1'b0, 1'b0, 1'b0, 16'hB4C5, 16'h0053);
    `CHK(r_addr, {1'b0, 7'h53, 16'hB4C4})
    `CHK(r_data, PM.mem[2])
  endtask
  // word, both bytes, upper byte and refused upper byte, in user and config space
  task automatic t_tbl_rd();
    logic [7:0] pg;
    logic [15:0] ea, e;
    logic [23:0] w;
    for (int p = 0; p < 2; p++)
      for (int m = 0; m < 5; m++)
      begin
        pg = p ? 8'h85 : 8'h00;
        ea = 16'h7A12 | 16'(m == 2 || m == 4);
        set_page(pg, 8'h00);
        dly = 4'(m);
        w = PM.mem[ea[4:1]];
        e = m == 0 ? w[15:0] : m == 1 ? {8'h00, w[7:0]} : m == 2 ? {8'h00, w[15:8]} :
          m == 3 ? {8'h00, w[23:16]} : 16'h0000;
        op(1, 1'b0, m > 2, m == 1 || m == 2, ea, 16'h0000);
        `CHK(r_addr, {pg, ea})
        `CHK(cfg_space, pg[7])
        `CHK(r_data, {8'h00, e})
      end
  endtask
  // back-to-back writes: word, upper byte, odd byte and refused upper byte
  task automatic t_tbl_wr();
    op(1, 1'b1, 1'b0, 1'b0, 16'h0008, 16'hBEEF);
    `CHK({pm_wr, pm_lane_en, pm_wdata[15:0]}, {1'b1, LANE_LOW_WORD, 16'hBEEF})
    op(1, 1'b1, 1'b1, 1'b0, 16'h0008, 16'h0077);
    `CHK({pm_wr, pm_lane_en, pm_wdata[23:16]}, {1'b1, LANE_HI, 8'h77})
    op(1, 1'b1, 1'b0, 1'b1, 16'h0009, 16'h0066);
    `CHK({pm_lane_en, pm_wdata[15:8]}, {LANE_B1, 8'h66})
    op(1, 1'b1, 1'b1, 1'b0, 16'h0009, 16'h0011);
    `CHK(pm_lane_en, LANE_NONE)
    idle();
    @(posedge clk_sys);
    #1 `CHK(PM.mem[4], 24'h7766EF)
  endtask
  // slow window read, then a window write that must be dropped
  task automatic t_window();
    logic [23:0] w;
    set_page(8'h85, 8'h5C);
    dly = 4'h9;
    w = PM.mem[5];
    op(2, 1'b0, 1'b0, 1'b0, 16'hF00B, 16'h0000);
    `CHK(r_addr, {1'b0, 8'h5C, 15'h700B})
    `CHK(r_data, {8'h00, w[15:0]})
    op(2, 1'b1, 1'b0, 1'b0, 16'h000A, 16'hDEAD);
    `CHK({win_wr_drop, pm_wr, pm_rd}, 3'h4)
    idle();
    @(posedge clk_sys);
    #1 `CHK(PM.mem[5], w)
  endtask
  // table write and window write together: table goes first, window write follows
  task automatic t_prio();
    `CHK(req_ready, 1'b1)
    {tbl_req, tbl_wr, tbl_high, tbl_byte, win_req, win_wr} = 6'h33;
    {tbl_ea, win_ea, tbl_wdata} = {16'h0010, 16'h0010, 16'h1234};
    @(posedge clk_sys);
    #1 `CHK({pm_wr, win_wr_drop, pm_addr}, {2'h2, 8'h85, 16'h0010})
    tbl_req = 1'b0;
    @(posedge clk_sys);
    #1 `CHK({pm_wr, win_wr_drop, pm_addr}, {2'h1, 1'b0, 8'h5C, 15'h0010})
    idle();
  endtask
  // reset for 8 cycles, then the scenarios
  initial
  begin
    {clk_sys, rstn, page_wr, win_page_wr, page_wdata, win_page_wdata, dly} = '0;
    {fetch_req, fetch_pc, tbl_req, tbl_wr, tbl_high, tbl_byte, tbl_ea} = '0;
    {tbl_wdata, win_req, win_wr, win_ea} = '0;
    repeat (8) @(posedge clk_sys);
    #1 `CHK(req_ready, 1'b1)
    rstn = 1'b1;
    `CHK(table_page_select, PAGE_RST)
    t_fetch();
    t_tbl_rd();
    t_tbl_wr();
    t_window();
    t_prio();
    stop_test();
  end
endmodule // testbench
